// ### rdm_defines.vh
`ifndef RDM_DEFINES_VH
`define RDM_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets, compared against haddr[7:2] with the low two bits taken as zero
// ---------------------------------------------------------------
`define RDM_ADDR_MSB        7
`define RDM_OFS_PIN0_CFG    8'h00
`define RDM_OFS_PIN1_CFG    8'h04
`define RDM_OFS_PIN2_CFG    8'h08
`define RDM_OFS_THRESH      8'h0c
`define RDM_OFS_STATUS      8'h10

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define RDM_SEL_MSB         5
`define RDM_INV_BIT         6
`define RDM_CFG_MSB         6
`define RDM_PQH_LSB         0
`define RDM_PQH_MSB         7
`define RDM_RTHR_LSB        8
`define RDM_RTHR_MSB        15
`define RDM_CCAM_LSB        16
`define RDM_CCAM_MSB        17
`define RDM_ST_PQ           0
`define RDM_ST_CCA          1
`define RDM_ST_CS           2
`define RDM_ST_CRC          3
`define RDM_ST_TX           4
`define RDM_ST_RX           5
`define RDM_HTRANS_ACT_BIT  1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RDM_CFG_RST         7'h00
`define RDM_PQH_RST         8'h00
`define RDM_RTHR_RST        8'h00
`define RDM_CCAM_RST        2'h0

// ---------------------------------------------------------------
// signal select codes
// ---------------------------------------------------------------
`define RDM_SEL_GPIO        6'h00
`define RDM_SEL_PQ          6'h08
`define RDM_SEL_CCA         6'h09
`define RDM_SEL_CS          6'h0e
`define RDM_SEL_CRC         6'h0f
`define RDM_SEL_SYM1        6'h16
`define RDM_SEL_SYM0        6'h17
`define RDM_SEL_TXPD        6'h1b
`define RDM_SEL_RXPD        6'h1c
`define RDM_SEL_STRB        6'h1d
`define RDM_SEL_LOW         6'h2f

// ---------------------------------------------------------------
// radio states and assessment modes
// ---------------------------------------------------------------
`define RDM_ST_RADIO_RX     5'h0d
`define RDM_ST_RADIO_RXEND  5'h0e
`define RDM_ST_RADIO_RXRST  5'h0f
`define RDM_ST_RADIO_TX     5'h13
`define RDM_ST_RADIO_TXEND  5'h14
`define RDM_CCA_ALWAYS      2'h0
`define RDM_CCA_RSSI        2'h1
`define RDM_CCA_NOPKT       2'h2
`define RDM_CCA_BOTH        2'h3

`endif

// ### rdm_pin_sel.v
`timescale 1ns/10ps
`include "rdm_defines.vh"

module rdm_pin_sel (
  // configuration
  input  wire [5:0] signal_select_field,
  input  wire       output_invert,
  // radio sources
  input  wire       pq_reached,
  input  wire       chan_clear,
  input  wire       carrier_sense,
  input  wire       crc_ok,
  input  wire [1:0] receive_symbol_bits,
  input  wire       rx_symbol_strobe,
  input  wire       tx_amp_powerdown_n,
  input  wire       rx_amp_powerdown_n,
  // ordinary port control
  input  wire       function_select,
  input  wire       periph_out,
  input  wire       periph_oe,
  input  wire       gpio_out,
  input  wire       gpio_dir,
  // resolved pin drive
  output reg        drive,
  output reg        drive_en
);

  reg raw;

  // ---------------------------------------------------------------
  // source select and port override
  // ---------------------------------------------------------------
  always @* begin
    raw = 1'b0;
    case (signal_select_field)
      `RDM_SEL_PQ:   raw = pq_reached;
      `RDM_SEL_CCA:  raw = chan_clear;
      `RDM_SEL_CS:   raw = carrier_sense;
      `RDM_SEL_CRC:  raw = crc_ok;
      `RDM_SEL_SYM1: raw = receive_symbol_bits[1];      // [R08]
      `RDM_SEL_SYM0: raw = receive_symbol_bits[0];      // [R08]
      `RDM_SEL_STRB: raw = rx_symbol_strobe;            // [R08]
      `RDM_SEL_TXPD: raw = tx_amp_powerdown_n;
      `RDM_SEL_RXPD: raw = rx_amp_powerdown_n;
      `RDM_SEL_LOW:  raw = 1'b0;                        // [R11]
      default:       raw = 1'b0;                        // [R12]
    endcase
    if (signal_select_field == `RDM_SEL_GPIO) begin
      // plain port control, no radio signal        [R02]
      drive    = function_select ? periph_out : gpio_out;
      drive_en = function_select ? periph_oe : gpio_dir;
    end else begin
      drive    = raw ^ output_invert;                   // [R11]
      drive_en = 1'b1;                                  // [R03]
    end
  end

endmodule

// ### rdm_debug_mux.v
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "rdm_defines.vh"

// Summary of operation
// [R01] each of three pins picks a radio status signal via its 6-bit select
// [R02] select zero leaves the pin under ordinary port control
// [R03] non-zero select overrides function select and forces output drive
// [R04] code 001000 shows preamble quality above the programmed threshold
// [R05] code 001001 shows clear channel, rssi below threshold, per mode
// [R06] code 001110 shows carrier sense, rssi above threshold
// [R07] code 001111 shows crc match flag, cleared on entering receive
// [R08] codes 010110, 010111, 011101 give symbol bits and symbol strobe
// [R09] code 011011 gives active-low transmit amplifier control
// [R10] code 011100 gives active-low receive amplifier control
// [R11] code 101111 drives low; inversion makes it a constant high
// [R12] reserved select codes drive low before inversion

module rdm_debug_mux (
  // clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // radio state machine sources
  input  wire [4:0]  radio_state,
  input  wire [7:0]  preamble_quality_indicator,
  input  wire [7:0]  rssi_level,
  input  wire        rx_packet_active,
  input  wire        crc_check_done,
  input  wire        crc_check_match,
  input  wire [1:0]  receive_symbol_bits,
  input  wire        rx_symbol_strobe,
  // ordinary port control for the three pins
  input  wire        port1_pin5_function_select,
  input  wire        port1_pin6_function_select,
  input  wire        port1_pin7_function_select,
  input  wire [2:0]  periph_out,
  input  wire [2:0]  periph_oe,
  input  wire [2:0]  gpio_out,
  input  wire [2:0]  gpio_dir,
  // pins, bit 0 is the pin behind pin0_output_config
  input  wire [2:0]  pin_in,
  output reg  [2:0]  pin_out,
  output reg  [2:0]  pin_oe,
  output reg  [2:0]  pin_in_sync
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // byte lanes touched by a transfer of the given size and offset
  function [3:0] byte_mask;
    input [2:0] size;
    input [1:0] ofs;
    begin
      case (size)
        3'h0:    byte_mask = 4'h1 << ofs;
        3'h1:    byte_mask = ofs[1] ? 4'hc : 4'h3;
        default: byte_mask = 4'hf;
      endcase
    end
  endfunction

  // merge written byte lanes into an old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0]  be;
    integer      k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = wdat[k*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg  [6:0]  cfg_r [0:2];
  reg  [6:0]  cfg_nxt [0:2];
  reg  [7:0]  pqh_r;
  reg  [7:0]  pqh_nxt;
  reg  [7:0]  rssi_thr_r;
  reg  [7:0]  rssi_thr_nxt;
  reg  [1:0]  asm_mode_r;
  reg  [1:0]  asm_mode_nxt;
  reg  [7:0]  wr_addr_r;
  reg         wr_pend_r;
  reg  [3:0]  wr_be_r;
  reg  [31:0] rdata_nxt;
  reg  [31:0] merged;
  reg  [4:0]  prev_state_r;
  reg         pq_reached_r;
  reg         chan_clear_r;
  reg         carrier_sense_r;
  reg         crc_ok_r;
  reg         crc_ok_nxt;
  reg         tx_pd_n_r;
  reg         rx_pd_n_r;
  reg  [1:0]  sym_bits_r;
  reg         sym_strobe_r;
  reg  [2:0]  pin_meta_r;
  reg         rssi_below;
  reg         cca_nxt;
  integer     i;
  integer     j;
  wire        take_w;
  wire [7:0]  addr_w;
  wire [2:0]  func_sel_w;
  wire [2:0]  drive_w;
  wire [2:0]  drive_en_w;
  wire        in_tx_w;
  wire        in_rx_w;
  wire        rx_enter_w;
  wire [5:0]  status_w;

  assign take_w     = hsel & hready & htrans[`RDM_HTRANS_ACT_BIT];
  assign addr_w     = {haddr[`RDM_ADDR_MSB:2], 2'h0};
  assign func_sel_w = {port1_pin7_function_select,
                       port1_pin6_function_select,
                       port1_pin5_function_select};

  // ---------------------------------------------------------------
  // bus address phase capture
  // ---------------------------------------------------------------
  // write is held until its data phase, when hwdata stands
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_be_r   <= 4'h0;
    end else begin
      wr_pend_r <= take_w & hwrite;
      if (take_w) begin
        wr_addr_r <= addr_w;
        wr_be_r   <= byte_mask(hsize, haddr[1:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // register next values from data-phase writes
  // ---------------------------------------------------------------
  always @* begin
    merged       = 32'h0;
    pqh_nxt      = pqh_r;
    rssi_thr_nxt = rssi_thr_r;
    asm_mode_nxt = asm_mode_r;
    for (i = 0; i < 3; i = i + 1) begin
      cfg_nxt[i] = cfg_r[i];
    end
    if (wr_pend_r) begin
      case (wr_addr_r)
        `RDM_OFS_PIN0_CFG: begin
          merged     = merge({25'h0, cfg_r[0]}, hwdata, wr_be_r);
          cfg_nxt[0] = merged[`RDM_CFG_MSB:0];
        end
        `RDM_OFS_PIN1_CFG: begin
          merged     = merge({25'h0, cfg_r[1]}, hwdata, wr_be_r);
          cfg_nxt[1] = merged[`RDM_CFG_MSB:0];
        end
        `RDM_OFS_PIN2_CFG: begin
          merged     = merge({25'h0, cfg_r[2]}, hwdata, wr_be_r);
          cfg_nxt[2] = merged[`RDM_CFG_MSB:0];
        end
        `RDM_OFS_THRESH: begin
          merged       = merge({14'h0, asm_mode_r, rssi_thr_r, pqh_r},
                               hwdata, wr_be_r);
          pqh_nxt      = merged[`RDM_PQH_MSB:`RDM_PQH_LSB];
          rssi_thr_nxt = merged[`RDM_RTHR_MSB:`RDM_RTHR_LSB];
          asm_mode_nxt = merged[`RDM_CCAM_MSB:`RDM_CCAM_LSB];
        end
        default: begin
          merged = 32'h0;                   // unmapped writes dropped
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (j = 0; j < 3; j = j + 1) begin
        cfg_r[j] <= `RDM_CFG_RST;
      end
      pqh_r      <= `RDM_PQH_RST;
      rssi_thr_r <= `RDM_RTHR_RST;
      asm_mode_r <= `RDM_CCAM_RST;
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        cfg_r[j] <= cfg_nxt[j];
      end
      pqh_r      <= pqh_nxt;
      rssi_thr_r <= rssi_thr_nxt;
      asm_mode_r <= asm_mode_nxt;
    end
  end

  // ---------------------------------------------------------------
  // read data, taken from next values so a write just ahead is seen
  // ---------------------------------------------------------------
  always @* begin
    rdata_nxt = 32'h0;
    case (addr_w)
      `RDM_OFS_PIN0_CFG: rdata_nxt = {25'h0, cfg_nxt[0]};
      `RDM_OFS_PIN1_CFG: rdata_nxt = {25'h0, cfg_nxt[1]};
      `RDM_OFS_PIN2_CFG: rdata_nxt = {25'h0, cfg_nxt[2]};
      `RDM_OFS_THRESH:   rdata_nxt = {14'h0, asm_mode_nxt,
                                      rssi_thr_nxt, pqh_nxt};
      `RDM_OFS_STATUS:   rdata_nxt = {26'h0, status_w};
      default:           rdata_nxt = 32'h0;
    endcase
  end

  // zero wait states, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take_w && !hwrite) begin
        hrdata <= rdata_nxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // radio status derivation
  // ---------------------------------------------------------------
  assign in_tx_w = (radio_state == `RDM_ST_RADIO_TX) |
                   (radio_state == `RDM_ST_RADIO_TXEND);
  assign in_rx_w = (radio_state == `RDM_ST_RADIO_RX) |
                   (radio_state == `RDM_ST_RADIO_RXEND) |
                   (radio_state == `RDM_ST_RADIO_RXRST);
  // entry into receive, also after a restart through the reset state
  assign rx_enter_w = (radio_state == `RDM_ST_RADIO_RX) &
                      (prev_state_r != `RDM_ST_RADIO_RX);

  // assessment result by mode
  always @* begin
    rssi_below = $signed(rssi_level) < $signed(rssi_thr_r);
    case (asm_mode_r)
      `RDM_CCA_ALWAYS: cca_nxt = 1'b1;
      `RDM_CCA_RSSI:   cca_nxt = rssi_below;
      `RDM_CCA_NOPKT:  cca_nxt = ~rx_packet_active;
      `RDM_CCA_BOTH:   cca_nxt = rssi_below & ~rx_packet_active;
      default:         cca_nxt = 1'b0;
    endcase
  end

  // crc flag: a match in the clearing cycle still sets it
  always @* begin
    crc_ok_nxt = crc_ok_r;
    if (rx_enter_w) begin
      crc_ok_nxt = 1'b0;                                   // [R07]
    end
    if (crc_check_done) begin
      crc_ok_nxt = crc_check_match;                        // [R07]
    end
  end

  // registered status sources
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_state_r    <= 5'h00;
      pq_reached_r    <= 1'b0;
      chan_clear_r    <= 1'b0;
      carrier_sense_r <= 1'b0;
      crc_ok_r        <= 1'b0;
      tx_pd_n_r       <= 1'b1;
      rx_pd_n_r       <= 1'b1;
      sym_bits_r      <= 2'h0;
      sym_strobe_r    <= 1'b0;
    end else begin
      prev_state_r    <= radio_state;
      pq_reached_r    <= preamble_quality_indicator > pqh_r;     // [R04]
      chan_clear_r    <= cca_nxt;                                // [R05]
      carrier_sense_r <= $signed(rssi_level) >
                         $signed(rssi_thr_r);                    // [R06]
      crc_ok_r        <= crc_ok_nxt;
      tx_pd_n_r       <= ~in_tx_w;                               // [R09]
      rx_pd_n_r       <= ~in_rx_w;                               // [R10]
      sym_bits_r      <= receive_symbol_bits;
      sym_strobe_r    <= rx_symbol_strobe;
    end
  end

  assign status_w = {~rx_pd_n_r, ~tx_pd_n_r, crc_ok_r,
                     carrier_sense_r, chan_clear_r, pq_reached_r};

  // ---------------------------------------------------------------
  // per-pin signal selection
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : pin_g
      rdm_pin_sel u_sel (
        .signal_select_field (cfg_r[g][`RDM_SEL_MSB:0]),   // [R01]
        .output_invert       (cfg_r[g][`RDM_INV_BIT]),
        .pq_reached          (pq_reached_r),
        .chan_clear          (chan_clear_r),
        .carrier_sense       (carrier_sense_r),
        .crc_ok              (crc_ok_r),
        .receive_symbol_bits (sym_bits_r),
        .rx_symbol_strobe    (sym_strobe_r),
        .tx_amp_powerdown_n  (tx_pd_n_r),
        .rx_amp_powerdown_n  (rx_pd_n_r),
        .function_select     (func_sel_w[g]),
        .periph_out          (periph_out[g]),
        .periph_oe           (periph_oe[g]),
        .gpio_out            (gpio_out[g]),
        .gpio_dir            (gpio_dir[g]),
        .drive               (drive_w[g]),
        .drive_en            (drive_en_w[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // pin drive registers and input synchroniser
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out     <= 3'h0;
      pin_oe      <= 3'h0;
      pin_meta_r  <= 3'h0;
      pin_in_sync <= 3'h0;
    end else begin
      pin_out     <= drive_w;
      pin_oe      <= drive_en_w;                           // [R03]
      pin_meta_r  <= pin_in;
      pin_in_sync <= pin_meta_r;
    end
  end

endmodule

// ### rdm_debug_mux_asserts.sv
`timescale 1ns/10ps
`include "rdm_defines.vh"

module rdm_debug_mux_asserts (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  // radio sources
  input wire [4:0]  radio_state,
  input wire [7:0]  preamble_quality_indicator,
  input wire [7:0]  rssi_level,
  input wire [1:0]  receive_symbol_bits,
  // port control and pins
  input wire        port1_pin5_function_select,
  input wire [2:0]  periph_out,
  input wire [2:0]  periph_oe,
  input wire [2:0]  gpio_out,
  input wire [2:0]  gpio_dir,
  input wire [2:0]  pin_out,
  input wire [2:0]  pin_oe
);
  // ----------------------------------------
  // shadow of pin0 config and thresholds
  // ----------------------------------------
  reg        wr_q;
  reg  [5:0] wa_q;
  reg  [6:0] c0_q;
  reg [17:0] th_q;
  reg  [1:0] up_q;
  wire [5:0] sel0 = c0_q[5:0];
  wire       inv0 = c0_q[6];
  wire [7:0] pqh  = th_q[7:0];
  wire [7:0] rthr = th_q[15:8];
  wire       sym1 = receive_symbol_bits[1];
  wire       g_out = port1_pin5_function_select ? periph_out[0] : gpio_out[0];
  wire       g_oe  = port1_pin5_function_select ? periph_oe[0] : gpio_dir[0];

  // follow word writes as the slave takes them; up_q skips reset echoes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wa_q <= 6'h00;
      c0_q <= 7'h00;
      th_q <= 18'h00000;
      up_q <= 2'h0;
    end else begin
      if (hready) begin
        wr_q <= hsel & htrans[1] & hwrite;
        wa_q <= haddr[7:2];
      end
      if (hready && wr_q && wa_q == 6'h00)
        c0_q <= hwdata[6:0];
      if (hready && wr_q && wa_q == 6'h03)
        th_q <= hwdata[17:0];
      if (up_q != 2'h3)
        up_q <= up_q + 2'h1;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------
  // pin0 behaviour per select code
  // ----------------------------------------
  a_gpio_passthru: assert property ($past(sel0) == 6'h00 &&
    up_q == 2'h3 |->
    pin_out[0] == $past(g_out) && pin_oe[0] == $past(g_oe))
    else $error("pin0 not following port control");
  a_debug_drives: assert property ($past(sel0) != 6'h00 &&
    up_q == 2'h3 |-> pin_oe[0])
    else $error("pin0 not driven in debug mode");
  a_pq_reached: assert property ($past(sel0) == 6'h08 &&
    up_q == 2'h3 && $past(th_q) == $past(th_q, 2) |-> pin_out[0] ==
    (($past(preamble_quality_indicator, 2) > $past(pqh, 2)) ^ $past(inv0)))
    else $error("preamble quality output wrong");
  a_carrier_sense: assert property ($past(sel0) == 6'h0e &&
    up_q == 2'h3 &&
    $past(th_q) == $past(th_q, 2) |-> pin_out[0] == (($signed($past(
    rssi_level, 2)) > $signed($past(rthr, 2))) ^ $past(inv0)))
    else $error("carrier sense output wrong");
  a_symbol_bit: assert property ($past(sel0) == 6'h16 &&
    up_q == 2'h3 |->
    pin_out[0] == ($past(sym1, 2) ^ $past(inv0)))
    else $error("symbol bit output wrong");
  a_tx_amp_low: assert property ($past(sel0) == 6'h1b &&
    up_q == 2'h3 |->
    pin_out[0] == (!($past(radio_state, 2) == `RDM_ST_RADIO_TX ||
    $past(radio_state, 2) == `RDM_ST_RADIO_TXEND) ^ $past(inv0)))
    else $error("tx amplifier control wrong");
  a_rx_amp_low: assert property ($past(sel0) == 6'h1c &&
    up_q == 2'h3 |->
    pin_out[0] == (!($past(radio_state, 2) inside {`RDM_ST_RADIO_RX,
    `RDM_ST_RADIO_RXEND, `RDM_ST_RADIO_RXRST}) ^ $past(inv0)))
    else $error("rx amplifier control wrong");
  a_const_level: assert property ($past(sel0) == 6'h2f &&
    up_q == 2'h3 |->
    pin_out[0] == $past(inv0)) else $error("constant level wrong");
  a_reserved_low: assert property (up_q == 2'h3 &&
    $past(sel0) inside {[6'h01:6'h07]} |-> pin_out[0] == $past(inv0))
    else $error("reserved code not low");
endmodule

bind rdm_debug_mux rdm_debug_mux_asserts u_rdm_debug_mux_asserts (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .radio_state, .preamble_quality_indicator, .rssi_level,
  .receive_symbol_bits, .port1_pin5_function_select, .periph_out,
  .periph_oe, .gpio_out, .gpio_dir, .pin_out, .pin_oe);

// ### rdm_fe_model.sv
`timescale 1ns/10ps

module rdm_fe_model (
  // pins from the device
  input  wire [2:0] pin_out,
  input  wire [2:0] pin_oe,
  // level seen back on the pins
  output wire [2:0] pin_in
);
  // released pins sit on the front-end pull-down
  assign pin_in = pin_out & pin_oe;
endmodule

// ### tb.sv
`timescale 1ns/10ps

module tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic  [1:0] htrans = 2'h0, sym = 2'h0;
  logic  [2:0] hsize = 3'h0, fsel = 3'h0, p_out = 3'h0, p_oe = 3'h0;
  logic  [2:0] g_out = 3'h0, g_dir = 3'h0;
  logic  [4:0] radio_state = 5'h01;
  logic  [7:0] pqv = 8'h00, rssi = 8'h00;
  logic        rx_act = 1'b0, crc_done = 1'b0, crc_match = 1'b0, strobe = 1'b0;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata;
  wire   [2:0] pin_out, pin_oe, pin_in, pin_sync;
  int          err_count = 0, num_checks = 0, cyc = 0;
  logic  [5:0] codes [12] = '{6'h08, 6'h09, 6'h0e, 6'h0f, 6'h16, 6'h17,
                              6'h1b, 6'h1c, 6'h1d, 6'h2f, 6'h01, 6'h3f};

  always #2 hclk = ~hclk;

  rdm_debug_mux u_rdm_debug_mux (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .radio_state(radio_state), .preamble_quality_indicator(pqv),
    .rssi_level(rssi), .rx_packet_active(rx_act),
    .crc_check_done(crc_done), .crc_check_match(crc_match),
    .receive_symbol_bits(sym), .rx_symbol_strobe(strobe),
    .port1_pin5_function_select(fsel[0]),
    .port1_pin6_function_select(fsel[1]),
    .port1_pin7_function_select(fsel[2]), .periph_out(p_out),
    .periph_oe(p_oe), .gpio_out(g_out), .gpio_dir(g_dir),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in_sync(pin_sync));
  rdm_fe_model u_rdm_fe_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task finish_test;
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: read %h wanted %h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: pins %b wanted %b", $time, got, exp);
    end
  endtask

  // ----------------------------------------
  // bus access and helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk_reg(q, exp);
    chk_reg({31'h0, hresp}, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // each of the twelve listed codes on all three pins, plain and inverted
  task automatic run_codes(input logic [11:0] expv);
    logic [31:0] v;
    for (int inv = 0; inv < 2; inv++) begin
      for (int k = 0; k < 12; k++) begin
        v = {25'h0, inv[0], codes[k]};
        wr(8'h00, v);
        wr(8'h04, v);
        wr(8'h08, v);
        tick(3);
        chk_pin(pin_out, {3{expv[11-k] ^ inv[0]}});
      end
    end
  endtask

  // cut a hang short
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(20);
    hresetn <= 1'b1;
    tick(1);
    for (int i = 0; i < 4; i++)
      rd(8'(4 * i), 32'h0);
    rd(8'h10, 32'h2);
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'h7f);
    wr(8'h14, 32'hff);
    rd(8'h14, 32'h0);
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h2);
    wr(8'h04, 32'h40);
    fsel <= 3'h1;
    p_out <= 3'h1;
    p_oe <= 3'h1;
    g_out <= 3'h6;
    g_dir <= 3'h3;
    tick(3);
    chk_pin(pin_out, 3'h7);
    chk_pin(pin_oe, 3'h3);
    tick(3);
    chk_pin(pin_sync, 3'h3);
    fsel <= 3'h7;
    p_oe <= 3'h0;
    g_dir <= 3'h0;
    wr(8'h00, 32'h2f);
    wr(8'h04, 32'h6f);
    wr(8'h08, 32'h2f);
    tick(3);
    chk_pin(pin_oe, 3'h7);
    chk_pin(pin_out, 3'h2);
    wr(8'h0c, 32'h00011040);
    rd(8'h0c, 32'h00011040);
    radio_state <= 5'h13;
    pqv <= 8'h41;
    rssi <= 8'hf0;
    rx_act <= 1'b1;
    sym <= 2'h2;
    strobe <= 1'b1;
    crc_match <= 1'b1;
    crc_done <= 1'b1;
    tick(1);
    crc_done <= 1'b0;
    run_codes(12'hd98);
    rd(8'h10, 32'h1b);
    radio_state <= 5'h0d;
    pqv <= 8'h40;
    rssi <= 8'h20;
    rx_act <= 1'b0;
    sym <= 2'h1;
    strobe <= 1'b0;
    run_codes(12'h260);
    for (int m = 0; m < 4; m++) begin
      wr(8'h0c, {14'h0, m[1:0], 16'h1040});
      tick(2);
      rd(8'h10, 32'h24 | {30'h0, ~m[0], 1'b0});
    end
    finish_test;
  end
endmodule
